// >>> efbm_core_model.sv
// efbm_core_model: emulated core issuing one access per call.
// assumes: shares pclk with the checker; go means the map is loaded.
`timescale 1ns/100ps
module efbm_core_model
  import efbm_pkg::*;
(
  // clock and start
  input  wire logic           pclk,
  input  wire logic           go,
  // access port
  output efbm_pkg::efbm_acc_s acc
);
  import efbm_pkg::*;
  initial acc = '0;
  // a released bus shows the inverted address, never a stale match
  task issue(input int k, input int a);
    wait (go);
    @(posedge pclk);
    acc <= '{1'b1, efbm_kind_e'(k[1:0]), a[27:0]};
    @(posedge pclk);
    acc <= '{1'b0, EFBM_FETCH, ~a[27:0]};
  endtask
endmodule

// >>> efbm_map.sv
// efbm_pkg: constants, types and register map of the fail-safe break map.
// efbm_map: combinational decode of one core access against the map.
// assumes: accesses come from logic on the same clock as the checker.
package efbm_pkg;
  // core access kinds
  typedef enum logic [1:0] {
    EFBM_FETCH = 2'b00,
    EFBM_READ  = 2'b01,
    EFBM_WRITE = 2'b10
  } efbm_kind_e;

  typedef struct packed {
    logic       valid;
    efbm_kind_e kind;
    logic [27:0] addr;
  } efbm_acc_s;

  typedef struct packed {
    logic       check_en;   // break checking on
    logic       rom_2m;     // internal rom reaches the second megabyte
    logic       mode_256;   // 0: 64 MB mode, 1: 256 MB mode
    logic [1:0] ram_code;   // 4096/12288/28672/61440 bytes
    logic [2:0] rom_code;   // 0,32,64,128,256,512,1024 KB
  } efbm_cfg_s;

  // register byte offsets
  localparam logic [7:0] EFBM_OFS_CFG      = 8'h00;
  localparam logic [7:0] EFBM_OFS_STATUS   = 8'h04;
  localparam logic [7:0] EFBM_OFS_IRQ_EN   = 8'h08;
  localparam logic [7:0] EFBM_OFS_IRQ_CLR  = 8'h0c;
  localparam logic [7:0] EFBM_OFS_BRK_ADDR = 8'h10;
  localparam logic [7:0] EFBM_OFS_BRK_INFO = 8'h14;

  // field positions and widths
  localparam int EFBM_CFG_W     = 8;
  localparam int EFBM_ST_FS_BIT = 0;
  localparam int EFBM_ST_WP_BIT = 1;
  localparam int EFBM_ST_W      = 2;
  localparam int EFBM_CNT_W     = 16;

  // values after reset
  localparam logic [7:0] EFBM_CFG_RST = 8'h80;
  localparam logic [1:0] EFBM_EN_RST  = 2'h0;

  // rom map
  localparam logic [27:0] EFBM_ROM_UNIT   = 28'h000_8000;
  localparam logic [2:0]  EFBM_ROM_MAXC   = 3'h6;
  localparam logic [27:0] EFBM_ROM_1M_END = 28'h00f_ffff;
  localparam logic [27:0] EFBM_ROM_2M_END = 28'h01f_ffff;

  // ram window
  localparam logic [27:0] EFBM_RAM_TOP_64   = 28'h3ff_efff;
  localparam logic [27:0] EFBM_RAM_TOP_256  = 28'hfff_efff;
  localparam logic [27:0] EFBM_RAM_AREA_64  = 28'h3ff_0000;
  localparam logic [27:0] EFBM_RAM_AREA_256 = 28'hfff_0000;
  localparam logic [27:0] EFBM_RAM_SZ0 = 28'h000_1000;
  localparam logic [27:0] EFBM_RAM_SZ1 = 28'h000_3000;
  localparam logic [27:0] EFBM_RAM_SZ2 = 28'h000_7000;
  localparam logic [27:0] EFBM_RAM_SZ3 = 28'h000_f000;
endpackage

`timescale 1ns/100ps
module efbm_map
  import efbm_pkg::*;
(
  // configuration and access
  input  wire efbm_pkg::efbm_cfg_s cfg,
  input  wire efbm_pkg::efbm_acc_s acc,
  // decode results
  output wire                      rom_hit,
  output wire                      ram_hit,
  output wire                      fs_hit,
  output wire                      wp_hit
);
  wire [27:0] rom_limit;
  wire [27:0] ram_size;
  wire [27:0] ram_top;
  wire [27:0] ram_area;
  wire [27:0] ram_base;
  wire        in_low_1m;
  wire        in_2nd_m;
  wire        in_ram_area;
  wire        is_write;

  // rom from zero upward, size doubles per code step
  assign rom_limit = EFBM_ROM_UNIT << (cfg.rom_code - 3'h1);
  assign rom_hit   = acc.valid && (cfg.rom_code != 3'h0) &&
                     (cfg.rom_code <= EFBM_ROM_MAXC) &&
                     (acc.addr < rom_limit);

  // ram ends at a fixed top and grows downward
  assign ram_size = (cfg.ram_code == 2'h0) ? EFBM_RAM_SZ0 :
                    (cfg.ram_code == 2'h1) ? EFBM_RAM_SZ1 :
                    (cfg.ram_code == 2'h2) ? EFBM_RAM_SZ2 : EFBM_RAM_SZ3;
  assign ram_top  = cfg.mode_256 ? EFBM_RAM_TOP_256 : EFBM_RAM_TOP_64;
  assign ram_area = cfg.mode_256 ? EFBM_RAM_AREA_256 : EFBM_RAM_AREA_64;
  assign ram_base = ram_top + 28'h000_0001 - ram_size;

  assign in_ram_area = (acc.addr >= ram_area) && (acc.addr <= ram_top);
  // the whole rounded-up window counts as memory, so no break above
  // a smaller target ram size
  assign ram_hit = acc.valid && in_ram_area &&
                   (acc.addr >= ram_base);

  assign is_write  = (acc.kind == EFBM_WRITE);
  assign in_low_1m = (acc.addr <= EFBM_ROM_1M_END);
  assign in_2nd_m  = cfg.rom_2m && !in_low_1m &&
                     (acc.addr <= EFBM_ROM_2M_END);

  // rom regions never fail-safe; any write there is protected
  assign wp_hit = acc.valid && cfg.check_en && is_write &&
                  (in_low_1m || in_2nd_m);
  // unmapped part of the ram area breaks on any access kind
  assign fs_hit = acc.valid && cfg.check_en && in_ram_area &&
                  (acc.addr < ram_base);
endmodule

// >>> efbm_monitor.sv
// efbm_monitor: port assertions for the break map.
// assumes: bound to efbm_top, one clock domain on pclk.
`timescale 1ns/100ps
module efbm_monitor
  import efbm_pkg::*;
(
  // clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // apb slave
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // core access and break report
  input wire efbm_pkg::efbm_acc_s acc,
  input wire logic                brk_valid,
  input wire logic                brk_wp,
  input wire logic [27:0]         brk_addr
);
  import efbm_pkg::*;
  logic [7:0] cfg;
  // shadow of the config word, so the map is known without peeking inside
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cfg <= EFBM_CFG_RST;
    else if (psel && penable && pready && pwrite && !pslverr &&
             paddr == EFBM_OFS_CFG) cfg <= pwdata[7:0];
  // map limits of the ram window
  wire [27:0] top = cfg[5] ? EFBM_RAM_TOP_256 : EFBM_RAM_TOP_64;
  wire [27:0] base = cfg[5] ? EFBM_RAM_AREA_256 : EFBM_RAM_AREA_64;
  wire [27:0] sz = cfg[4:3] == 2'h0 ? EFBM_RAM_SZ0 :
                   cfg[4:3] == 2'h1 ? EFBM_RAM_SZ1 :
                   cfg[4:3] == 2'h2 ? EFBM_RAM_SZ2 : EFBM_RAM_SZ3;
  wire [27:0] low = top + 28'h000_0001 - sz;
  wire        on = acc.valid && cfg[7];
  wire        rd = acc.valid && acc.kind != EFBM_WRITE;
  wire        in_ram = acc.addr >= base && acc.addr <= top;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wp_brk;
    brk_valid && brk_wp && brk_addr == $past(acc.addr);
  endsequence
  sequence s_fs_brk;
    brk_valid && !brk_wp && brk_addr == $past(acc.addr);
  endsequence
  wp_low_a: assert property (
    on && acc.kind == EFBM_WRITE && acc.addr <= EFBM_ROM_1M_END |=> s_wp_brk)
    else $error("low rom write gave no write-protect break");
  rd_low_a: assert property (
    rd && acc.addr <= EFBM_ROM_1M_END |=> !brk_valid)
    else $error("low rom read raised a break");
  rom_two_a: assert property (
    rd && cfg[6] && acc.addr <= EFBM_ROM_2M_END |=> !brk_valid)
    else $error("second megabyte read raised a break");
  ram_fs_a: assert property (
    on && in_ram && acc.addr < low |=> s_fs_brk)
    else $error("unmapped ram access gave no fail-safe break");
  ram_map_a: assert property (
    acc.valid && in_ram && acc.addr >= low |=> !brk_valid)
    else $error("mapped ram access raised a break");
  brk_cause_a: assert property (
    brk_valid |-> $past(acc.valid))
    else $error("break without an access");
  addr_hold_a: assert property (
    !brk_valid |-> $stable(brk_addr))
    else $error("break address moved without a break");
  apb_ready_a: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not a single cycle pulse");
endmodule

bind efbm_top efbm_monitor mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .acc(acc),
  .brk_valid(brk_valid), .brk_wp(brk_wp), .brk_addr(brk_addr));

// >>> efbm_top.sv
// efbm_top: address-map checker of an emulated core with an apb slave.
// assumes: core access port runs on pclk; debug software configures the
// map over apb before the core leaves reset.
//
// Summary of operation
// - internal rom maps from zero, 0 to 1024 KB by setting
// - internal ram ends at fixed top, grows down by chosen size
// - fetches and reads in lowest megabyte never fail-safe break
// - writes into the lowest megabyte raise a write-protect break
// - with rom in second megabyte, its reads never fail-safe break
// - any access to unmapped internal ram area raises fail-safe break
// - odd target ram sizes use next larger map, top unused not trapped
`timescale 1ns/100ps
module efbm_top
  import efbm_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // emulated core access
  input  wire efbm_pkg::efbm_acc_s acc,
  // break report to debug controller
  output logic                     brk_valid,
  output logic                     brk_wp,
  output logic [27:0]              brk_addr,
  // interrupt
  output logic                     irq
);
  import efbm_pkg::*;

  efbm_cfg_s            cfg;
  logic [EFBM_ST_W-1:0] status;
  logic [EFBM_ST_W-1:0] irq_en;
  logic [EFBM_CNT_W-1:0] brk_cnt;
  logic [1:0]           last_kind;

  wire rom_hit;
  wire ram_hit;
  wire fs_hit;
  wire wp_hit;

  // access decode against the current map
  efbm_map u_map (
    .cfg     (cfg),
    .acc     (acc),
    .rom_hit (rom_hit),
    .ram_hit (ram_hit),
    .fs_hit  (fs_hit),
    .wp_hit  (wp_hit)
  );

  // apb decode
  wire apb_setup = psel && !penable;
  wire apb_wr    = psel && penable && pready && pwrite;
  wire sel_cfg   = (paddr == EFBM_OFS_CFG);
  wire sel_st    = (paddr == EFBM_OFS_STATUS);
  wire sel_en    = (paddr == EFBM_OFS_IRQ_EN);
  wire sel_clr   = (paddr == EFBM_OFS_IRQ_CLR);
  wire sel_addr  = (paddr == EFBM_OFS_BRK_ADDR);
  wire sel_info  = (paddr == EFBM_OFS_BRK_INFO);
  wire sel_ro    = sel_st || sel_addr || sel_info;
  wire sel_any   = sel_cfg || sel_ro || sel_en || sel_clr;
  // write to a read-only word, read of the clear word, or any access to an unmapped word
  wire bad_acc   = !sel_any || (pwrite && sel_ro) ||
                   (!pwrite && sel_clr);

  // break events: write protect wins if both ever coincide
  wire brk_hit = fs_hit || wp_hit;
  wire [EFBM_ST_W-1:0] set_bits = {wp_hit, fs_hit};
  wire [EFBM_ST_W-1:0] clr_bits =
    (apb_wr && sel_clr) ? pwdata[EFBM_ST_W-1:0] : '0;
  // set wins over a clear in the same cycle
  wire [EFBM_ST_W-1:0] next_status = (status & ~clr_bits) | set_bits;

  wire [31:0] rd_info = {8'h00, 4'h0, rom_hit, ram_hit, last_kind,
                         brk_cnt};
  wire [31:0] next_prdata =
    sel_cfg  ? {{(32-EFBM_CFG_W){1'b0}}, cfg} :
    sel_st   ? {{(32-EFBM_ST_W){1'b0}}, status} :
    sel_en   ? {{(32-EFBM_ST_W){1'b0}}, irq_en} :
    sel_addr ? {4'h0, brk_addr} :
    sel_info ? rd_info : 32'h0000_0000;

  // one wait-free access phase: pready rises on the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      prdata  <= (apb_setup && !pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= apb_setup && bad_acc;
    end
  end

  // software registers; the map is only meant to change while the
  // core is held in reset, nothing here guards against a late write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg    <= EFBM_CFG_RST;
      irq_en <= EFBM_EN_RST;
    end else begin
      if (apb_wr && sel_cfg) begin
        cfg <= pwdata[EFBM_CFG_W-1:0];
      end
      if (apb_wr && sel_en) begin
        irq_en <= pwdata[EFBM_ST_W-1:0];
      end
    end
  end

  // sticky status and interrupt level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & irq_en);
    end
  end

  // one report per offending access, address captured with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_valid <= 1'b0;
      brk_wp    <= 1'b0;
      brk_addr  <= 28'h000_0000;
      brk_cnt   <= '0;
      last_kind <= 2'h0;
    end else begin
      brk_valid <= brk_hit;
      if (brk_hit) begin
        brk_wp    <= wp_hit;
        brk_addr  <= acc.addr;
        brk_cnt   <= brk_cnt + 16'h0001;
        last_kind <= acc.kind;
      end
    end
  end
endmodule

// >>> emulator_failsafe_break_map_tb.sv
// emulator_failsafe_break_map_tb: design against a reference model.
// assumes: efbm_top, efbm_core_model; 100 ns clock.
`timescale 1ns/100ps
module emulator_failsafe_break_map_tb;
  import efbm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, go, err;
  logic        pready, pslverr, brk_valid, brk_wp, irq;
  logic [7:0]  paddr, cfg;
  logic [31:0] pwdata, prdata, rd;
  logic [27:0] brk_addr;
  efbm_acc_s   acc;
  int          error_cnt, tests_run, cyc, st, tp, lo, nbrk, lastk, lasta;
  int          szt[4] = '{4096, 12288, 28672, 61440};
  efbm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .acc(acc),
    .brk_valid(brk_valid), .brk_wp(brk_wp), .brk_addr(brk_addr), .irq(irq));
  efbm_core_model core (.pclk(pclk), .go(go), .acc(acc));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // apb master: data taken at the edge where pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // the core is held while the map changes, as the debugger must do
  task set_cfg(input logic [7:0] c);
    go <= 1'b0;
    cfg = c;
    apb(1'b1, 8'h00, {24'h00_0000, c});
    go <= 1'b1;
  endtask
  // reference: 0 none, 2 fail-safe, 3 write-protect
  function automatic int model(int k, int a);
    int t;
    if (!cfg[7]) return 0;
    if (k == 2 && (a < 'h10_0000 || (cfg[6] && a < 'h20_0000))) return 3;
    t = cfg[5] ? 'hfff_efff : 'h3ff_efff;
    if (a >= t - 'hefff && a <= t - szt[cfg[4:3]]) return 2;
    return 0;
  endfunction
  task access(input int k, input int a);
    int e;
    e = model(k, a);
    core.issue(k, a);
    @(negedge pclk);
    chk(brk_valid, e[1]);
    if (e[1]) begin
      chk(brk_wp, e[0]);
      chk(brk_addr, a);
      st |= e[0] ? 2 : 1;
      nbrk++;
      lastk = k;
      lasta = a;
    end
  endtask
  // a hang ends the run as a mismatch
  always @(posedge pclk) if (++cyc == 5000) begin
    error_cnt++;
    end_of_test;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, go} = '0;
    presetn = 1'b0;
    cfg = 8'h80;
    void'($urandom(7));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 0);
    chk(rd, 32'h0000_0080);
    chk(err, 1'b0);
    apb(1'b0, 8'hfc, 0);
    chk(err, 1'b1);
    apb(1'b0, 8'h0c, 0);
    chk(err, 1'b1);
    apb(1'b1, 8'h08, 32'h0000_0003);
    // every ram size in both modes, at each edge of the mapped window
    for (int m = 0; m < 2; m++) for (int r = 0; r < 4; r++) begin
      set_cfg(8'h80 | m << 5 | r << 3);
      tp = m ? 'hfff_efff : 'h3ff_efff;
      lo = tp + 1 - szt[r];
      access(1, lo - 1);
      access(0, lo);
      access(2, tp);
      access(0, tp - 'hefff);
    end
    set_cfg(8'hc6);
    access(2, 'h10);
    access(0, 'h7_ffff);
    access(1, 'h1f_ffff);
    access(2, 'h10_0000);
    set_cfg(8'h86);
    access(2, 'h1f_fffc);
    set_cfg(8'h85);
    access(0, 'h8_0000); // above a 512 KB rom only an event break traps
    repeat (24) access($urandom % 3, $urandom & 'h1f_ffff);
    chk(irq, st != 0);
    apb(1'b0, 8'h04, 0);
    chk(rd, st);
    apb(1'b1, 8'h0c, 32'h0000_0003);
    apb(1'b0, 8'h04, 0);
    chk(rd, 0);
    chk(irq, 1'b0);
    apb(1'b1, 8'h08, 32'h0000_0001);
    apb(1'b0, 8'h08, 0);
    chk(rd, 32'h0000_0001);
    access(2, 0);
    chk(irq, 1'b0);
    access(1, 'h3ff_0000);
    chk(irq, 1'b1);
    set_cfg(8'h06);
    access(2, 0);
    // break info: kind of the last break and the running break count
    apb(1'b0, 8'h14, 0);
    chk(rd, {14'h0, lastk[1:0], nbrk[15:0]});
    apb(1'b0, 8'h10, 0);
    chk(rd, lasta);
    end_of_test;
  end
endmodule
